// [inc/sma_pkg.sv]
// Constants, register map and types of the sample memory analysis block.
package sma_pkg;
  // Memory geometry: 16 channels in 4 groups, fixed depth per channel.
  localparam int          NCH       = 16;
  localparam int          NGRP      = 4;
  localparam int          AW        = 13;
  localparam logic [13:0] DEPTH     = 14'h2000;
  localparam logic [13:0] ASCII_MAX = 14'h03E8;
  localparam logic [13:0] RAW_MAX   = 14'h1388;
  localparam logic signed [15:0] OFS_MAX = 16'(DEPTH);

  // Register byte offsets.
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_CHAN   = 8'h0C;
  localparam logic [7:0] OFS_GROUPS = 8'h10;
  localparam logic [7:0] OFS_ASSIGN = 8'h14;
  localparam logic [7:0] OFS_ARM    = 8'h18;
  localparam logic [7:0] OFS_CONFIG = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  localparam logic [7:0] OFS_LOC    = 8'h28;

  // Field positions.
  localparam int CMD_CNT_BIT = 4;
  localparam int CMD_OFS_BIT = 5;
  localparam int CMD_SEL_BIT = 6;
  localparam int CFG_ACT_LSB = 1;
  localparam int STAT_ERR    = 1;
  localparam int STAT_CODE   = 2;

  // Reset values.
  localparam logic [15:0] RST_ASSIGN = 16'h0000;
  localparam logic [3:0]  RST_ARM    = 4'h0;
  localparam logic [3:0]  RST_GROUPS = 4'h1;

  // Error LED blink half period.
  localparam int CLK_HZ       = 25000000;
  localparam int BLINK_MS     = 100;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] ACT_ONE = 2'h0;
  localparam logic [1:0] ACT_TWO = 2'h1;
  localparam logic [12:0] AMB_ONE = 13'h0003;
  localparam logic [12:0] AMB_TWO = 13'h0001;

  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ALPHA = 8'h37;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_LF    = 8'h0A;

  localparam logic [2:0] ERR_RANGE = 3'h1;
  localparam logic [2:0] ERR_ROUTE = 3'h2;
  localparam logic [2:0] ERR_OP    = 3'h3;

  typedef enum logic [3:0] {
    OP_HIGH = 4'h0, OP_LOW = 4'h1, OP_MEAN = 4'h2, OP_RMS = 4'h3,
    OP_RISE = 4'h4, OP_FALL = 4'h5, OP_ASCII = 4'h6, OP_RAW = 4'h7,
    OP_TAGS = 4'h8
  } op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_CHECK = 3'h1, S_RD = 3'h3, S_PROC = 3'h2,
    S_EMIT = 3'h6, S_DIV = 3'h7, S_ROOT = 3'h5, S_TAG = 3'h4
  } state_t;
endpackage

// [core/sample_memory_analysis.sv]
// Retrieval engine over per-channel sample memory with time-tag counters.
`timescale 1ns/100ps

// Function
// - Run over count; default full channel depth.
// - Text and raw queries need count, else error.
// - Offset signed from trigger; default zero.
// - Trigger address rounded down by up to 3/1/0 samples.
// - One channel per query; default channel 1.
// - Unassigned channel raises error, returns nothing.
// - Error LED blinks while a query runs.
// - Armed channel: disarm group, trigger at write pointer.
// - Max, min and mean over the window.
// - Peak and step results carry relative location.
// - Text results limited to 1000 values.
// - Raw results limited to 5000 words.
// - Raw words are 16-bit two's complement.
// - Raw words go high byte first.
// - Largest rising and falling consecutive step.
// - True RMS: root of mean square.
// - Tag counters tick on selected stamp clock.
// - Sync pulse zeroes tags, counting resumes.
// - Tag counter freezes at its group trigger.
// - Tag counters are 32 bits, wrapping.
// - Tag read lists groups; default group 1.
module sample_memory_analysis #(
  parameter int BLINK_CYCLES = sma_pkg::BLINK_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        smp_valid,
  input  wire logic [3:0]  smp_chan,
  input  wire logic [15:0] smp_data,
  input  wire logic [3:0]  grp_trig,
  input  wire logic        sync_pulse,
  input  wire logic        tick_fast,
  input  wire logic        tick_slow,
  output logic [7:0]       out_byte,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic             err_led
);
  import sma_pkg::*;

  typedef struct packed {
    state_t              st;
    logic                awready, wready, bvalid, arready, rvalid;
    logic [1:0]          bresp, rresp;
    logic [31:0]         rdata;
    logic                aw_ok, w_ok;
    logic [7:0]          awa;
    logic [31:0]         wd;
    logic [3:0]          ws;
    op_t                 op;
    logic                cnt_g, ofs_g, sel_g;
    logic [13:0]         count;
    logic [15:0]         offset;
    logic [4:0]          chan;
    logic [3:0]          groups, gsel, arm, frz;
    logic [15:0]         amask;
    logic                src;
    logic [1:0]          act;
    logic                err;
    logic [2:0]          code;
    logic [31:0]         result, loc;
    logic [15:0][12:0]   wptr;
    logic [3:0][12:0]    trig;
    logic [3:0][31:0]    tag;
    logic [3:0]          ch;
    logic [12:0]         base;
    logic [13:0]         n, idx;
    logic signed [15:0]  mx, mn, prev, cur;
    logic signed [16:0]  rise, fall;
    logic [15:0]         mxl, mnl, rsl, fll;
    logic signed [29:0]  sum;
    logic [45:0]         sq, num;
    logic [14:0]         rem;
    logic [5:0]          dcnt;
    logic                neg;
    logic [15:0]         root;
    logic [3:0]          rcnt;
    logic [2:0]          bcnt;
    logic [1:0]          tg;
    logic [7:0]          obyte;
    logic                ovalid;
    logic [21:0]         blink;
    logic                led;
  } state_all_t;

  state_all_t s_r, s_nxt;
  logic [15:0] mem [NCH*DEPTH];
  logic signed [15:0] rd_q;
  logic [12:0] rd_addr;

  // Current value of the register at byte address a, with a hit flag.
  function automatic logic [32:0] regval(state_all_t s, logic [7:0] a);
    case (a)
      OFS_CMD:    regval = {1'b1, 25'h0, s.sel_g, s.ofs_g, s.cnt_g, s.op};
      OFS_COUNT:  regval = {1'b1, 18'h0, s.count};
      OFS_OFFSET: regval = {1'b1, 16'h0, s.offset};
      OFS_CHAN:   regval = {1'b1, 27'h0, s.chan};
      OFS_GROUPS: regval = {1'b1, 28'h0, s.groups};
      OFS_ASSIGN: regval = {1'b1, 16'h0, s.amask};
      OFS_ARM:    regval = {1'b1, 28'h0, s.arm};
      OFS_CONFIG: regval = {1'b1, 29'h0, s.act, s.src};
      OFS_STATUS: regval = {1'b1, 27'h0, s.code, s.err, s.st != S_IDLE};
      OFS_RESULT: regval = {1'b1, s.result};
      OFS_LOC:    regval = {1'b1, s.loc};
      default:    regval = 33'h0;
    endcase
  endfunction

  function automatic logic [7:0] hexc(logic [3:0] v);
    hexc = (v < 4'hA) ? CH_ZERO + {4'h0, v} : CH_ALPHA + {4'h0, v};
  endfunction

  logic [32:0]        rv;
  logic [31:0]        wm, wv;
  logic [12:0]        tp;
  logic [15:0]        rel;
  logic signed [16:0] d;
  logic signed [31:0] p;
  logic [15:0]        rt, dt;
  logic [1:0]         g;
  logic               last, fire;

  assign rd_addr = s_r.base + s_r.idx[12:0];

  always_comb begin
    s_nxt = s_r;
    rv    = 33'h0;
    wm    = {{8{s_r.ws[3]}}, {8{s_r.ws[2]}}, {8{s_r.ws[1]}}, {8{s_r.ws[0]}}};
    wv    = 32'h0;
    tp    = 13'h0;
    rel   = s_r.offset + {2'h0, s_r.idx};
    d     = {rd_q[15], rd_q} - {s_r.prev[15], s_r.prev};
    p     = rd_q * rd_q;
    rt    = s_r.root | (16'h0001 << s_r.rcnt);
    dt    = {s_r.rem, s_r.num[45]};
    g     = s_r.ch[3:2];
    last  = (s_r.idx + 14'h0001) == s_r.n;
    fire  = 1'b0;

    // ----------------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------------
    if (awvalid && s_r.awready) begin
      s_nxt.aw_ok   = 1'b1;
      s_nxt.awa     = awaddr;
      s_nxt.awready = 1'b0;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_ok   = 1'b1;
      s_nxt.wd     = wdata;
      s_nxt.ws     = wstrb;
      s_nxt.wready = 1'b0;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end
    if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
      rv           = regval(s_r, s_r.awa);
      wv           = (rv[31:0] & ~wm) | (s_r.wd & wm);
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = rv[32] ? RESP_OKAY : RESP_SLVERR;
      case (s_r.awa)
        OFS_CMD: begin
          // A command written while busy is dropped; results stay intact.
          if (s_r.st == S_IDLE) begin
            s_nxt.op    = op_t'(wv[3:0]);
            s_nxt.cnt_g = wv[CMD_CNT_BIT];
            s_nxt.ofs_g = wv[CMD_OFS_BIT];
            s_nxt.sel_g = wv[CMD_SEL_BIT];
            s_nxt.err   = 1'b0;
            s_nxt.code  = 3'h0;
            s_nxt.st    = S_CHECK;
          end
        end
        OFS_COUNT:  s_nxt.count  = wv[13:0];
        OFS_OFFSET: s_nxt.offset = wv[15:0];
        OFS_CHAN:   s_nxt.chan   = wv[4:0];
        OFS_GROUPS: s_nxt.groups = wv[3:0];
        OFS_ASSIGN: s_nxt.amask  = wv[15:0];
        OFS_ARM:    s_nxt.arm    = wv[3:0];
        OFS_CONFIG: begin
          s_nxt.src = wv[0];
          s_nxt.act = wv[CFG_ACT_LSB +: 2];
        end
        default: ;
      endcase
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
    if (arvalid && s_r.arready) begin
      rv            = regval(s_r, araddr);
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rdata   = rv[31:0];
      s_nxt.rresp   = rv[32] ? RESP_OKAY : RESP_SLVERR;
    end

    // ----------------------------------------------------------------------
    // Acquisition pointers, triggers and time tags
    // ----------------------------------------------------------------------
    if (smp_valid)
      s_nxt.wptr[smp_chan] = s_r.wptr[smp_chan] + 13'h0001;
    for (int i = 0; i < NGRP; i++) begin
      // The stored trigger is rounded down to the interleave step.
      if (grp_trig[i] && s_r.arm[i]) begin
        tp = s_r.wptr[4*i];
        case (s_r.act)
          ACT_ONE: s_nxt.trig[i] = tp & ~AMB_ONE;
          ACT_TWO: s_nxt.trig[i] = tp & ~AMB_TWO;
          default: s_nxt.trig[i] = tp;
        endcase
        s_nxt.arm[i] = 1'b0;
      end
      if (sync_pulse) begin
        s_nxt.tag[i] = 32'h0;
        s_nxt.frz[i] = 1'b0;
      end else if (!s_r.frz[i] && (s_r.src ? tick_slow : tick_fast)) begin
        s_nxt.tag[i] = s_r.tag[i] + 32'h1;
      end
      if (grp_trig[i] && s_r.arm[i])
        s_nxt.frz[i] = 1'b1;
    end

    // ----------------------------------------------------------------------
    // Output byte handshake and error LED
    // ----------------------------------------------------------------------
    if (s_r.ovalid && out_ready)
      s_nxt.ovalid = 1'b0;
    if (s_r.st != S_IDLE) begin
      s_nxt.blink = s_r.blink + 22'h1;
      if (s_r.blink == 22'(BLINK_CYCLES - 1)) begin
        s_nxt.blink = 22'h0;
        s_nxt.led   = ~s_r.led;
      end
    end else begin
      s_nxt.blink = 22'h0;
      s_nxt.led   = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Retrieval sequencer
    // ----------------------------------------------------------------------
    case (s_r.st)
      S_IDLE: ;
      S_CHECK: begin
        s_nxt.ch   = s_r.sel_g ? 4'(s_r.chan - 5'h1) : 4'h0;
        s_nxt.gsel = s_r.sel_g ? s_r.groups : RST_GROUPS;
        s_nxt.tg   = 2'h0;
        s_nxt.n    = s_r.cnt_g ? s_r.count : DEPTH;
        s_nxt.st   = S_IDLE;
        if (s_r.op > OP_TAGS) begin
          s_nxt.err  = 1'b1;
          s_nxt.code = ERR_OP;
        end else if (s_r.op == OP_TAGS) begin
          s_nxt.st = S_TAG;
        end else if (((s_r.op == OP_ASCII || s_r.op == OP_RAW)
                      && !s_r.cnt_g)
                     || (s_r.cnt_g && (s_r.count == 14'h0
                                       || s_r.count > DEPTH))
                     || (s_r.op == OP_ASCII && s_r.count > ASCII_MAX)
                     || (s_r.op == OP_RAW && s_r.count > RAW_MAX)
                     || (s_r.sel_g && (s_r.chan == 5'h0
                                       || s_r.chan > 5'(NCH)))
                     || (s_r.ofs_g && ($signed(s_r.offset) > OFS_MAX
                                       || $signed(s_r.offset) < -OFS_MAX)))
        begin
          s_nxt.err  = 1'b1;
          s_nxt.code = ERR_RANGE;
        end else if (!s_r.amask[s_nxt.ch]) begin
          s_nxt.err  = 1'b1;
          s_nxt.code = ERR_ROUTE;
        end else begin
          g = s_nxt.ch[3:2];
          tp = s_r.trig[g];
          if (s_r.arm[g]) begin
            s_nxt.arm[g]  = 1'b0;
            tp            = s_r.wptr[s_nxt.ch];
            s_nxt.trig[g] = tp;
          end
          if (!s_r.ofs_g)
            s_nxt.offset = 16'h0;
          s_nxt.base = tp + (s_r.ofs_g ? s_r.offset[12:0] : 13'h0);
          s_nxt.idx  = 14'h0;
          s_nxt.sum  = 30'sh0;
          s_nxt.sq   = 46'h0;
          s_nxt.st   = S_RD;
        end
      end
      S_RD: s_nxt.st = S_PROC;
      S_PROC: begin
        s_nxt.cur  = rd_q;
        s_nxt.prev = rd_q;
        s_nxt.st   = S_RD;
        if (s_r.op == OP_ASCII || s_r.op == OP_RAW) begin
          s_nxt.bcnt = 3'h0;
          s_nxt.st   = S_EMIT;
        end else begin
          if (s_r.idx == 14'h0 || rd_q > s_r.mx) begin
            s_nxt.mx  = rd_q;
            s_nxt.mxl = rel;
          end
          if (s_r.idx == 14'h0 || rd_q < s_r.mn) begin
            s_nxt.mn  = rd_q;
            s_nxt.mnl = rel;
          end
          if (s_r.idx == 14'h1 || d > s_r.rise) begin
            s_nxt.rise = d;
            s_nxt.rsl  = rel;
          end
          if (s_r.idx == 14'h1 || d < s_r.fall) begin
            s_nxt.fall = d;
            s_nxt.fll  = rel;
          end
          s_nxt.sum = s_r.sum + 30'(rd_q);
          s_nxt.sq  = s_r.sq + 46'($unsigned(p));
          s_nxt.idx = s_r.idx + 14'h1;
          if (last) begin
            s_nxt.st   = S_IDLE;
            s_nxt.rem  = 15'h0;
            s_nxt.dcnt = 6'h0;
            s_nxt.neg  = s_nxt.sum[29];
            case (s_r.op)
              OP_HIGH: {s_nxt.result, s_nxt.loc} =
                {{16{s_nxt.mx[15]}}, s_nxt.mx, {16{s_nxt.mxl[15]}}, s_nxt.mxl};
              OP_LOW: {s_nxt.result, s_nxt.loc} =
                {{16{s_nxt.mn[15]}}, s_nxt.mn, {16{s_nxt.mnl[15]}}, s_nxt.mnl};
              OP_RISE: {s_nxt.result, s_nxt.loc} =
                {{15{s_nxt.rise[16]}}, s_nxt.rise,
                 {16{s_nxt.rsl[15]}}, s_nxt.rsl};
              OP_FALL: {s_nxt.result, s_nxt.loc} =
                {{15{s_nxt.fall[16]}}, s_nxt.fall,
                 {16{s_nxt.fll[15]}}, s_nxt.fll};
              OP_MEAN: begin
                s_nxt.num = 46'(s_nxt.neg ? -s_nxt.sum : s_nxt.sum);
                s_nxt.st  = S_DIV;
              end
              default: begin
                s_nxt.num = s_nxt.sq;
                s_nxt.st  = S_DIV;
              end
            endcase
          end
        end
      end
      S_EMIT: begin
        if (!s_nxt.ovalid) begin
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          fire       = 1'b1;
          case (s_r.op)
            OP_RAW: begin
              s_nxt.obyte = s_r.bcnt[0] ? s_r.cur[7:0] : s_r.cur[15:8];
              fire = s_r.bcnt < 3'h2;
            end
            OP_ASCII: begin
              case (s_r.bcnt)
                3'h0: s_nxt.obyte = hexc(s_r.cur[15:12]);
                3'h1: s_nxt.obyte = hexc(s_r.cur[11:8]);
                3'h2: s_nxt.obyte = hexc(s_r.cur[7:4]);
                3'h3: s_nxt.obyte = hexc(s_r.cur[3:0]);
                3'h4: s_nxt.obyte = last ? CH_LF : CH_COMMA;
                default: fire = 1'b0;
              endcase
            end
            default: begin
              s_nxt.obyte = s_r.tag[s_r.tg][8*(3-s_r.bcnt[1:0]) +: 8];
              fire = s_r.bcnt < 3'h4;
            end
          endcase
          s_nxt.ovalid = fire;
          if (!fire) begin
            s_nxt.idx = s_r.idx + 14'h1;
            s_nxt.tg  = s_r.tg + 2'h1;
            if (s_r.op == OP_TAGS)
              s_nxt.st = (s_r.tg == 2'h3) ? S_IDLE : S_TAG;
            else
              s_nxt.st = last ? S_IDLE : S_RD;
          end
        end
      end
      S_TAG: begin
        s_nxt.bcnt = 3'h0;
        s_nxt.tg   = s_r.tg + 2'h1;
        if (s_r.gsel[s_r.tg]) begin
          s_nxt.tg = s_r.tg;
          s_nxt.st = S_EMIT;
        end else if (s_r.tg == 2'h3) begin
          s_nxt.st = S_IDLE;
        end
      end
      S_DIV: begin
        // Restoring division, one quotient bit per cycle, shared by
        // the mean and the mean of squares.
        s_nxt.dcnt = s_r.dcnt + 6'h1;
        if (dt >= {2'h0, s_r.n}) begin
          s_nxt.rem = 15'(dt - {2'h0, s_r.n});
          s_nxt.num = {s_r.num[44:0], 1'b1};
        end else begin
          s_nxt.rem = dt[14:0];
          s_nxt.num = {s_r.num[44:0], 1'b0};
        end
        if (s_r.dcnt == 6'd45) begin
          s_nxt.loc = 32'h0;
          if (s_r.op == OP_MEAN) begin
            s_nxt.result = s_r.neg ? -s_nxt.num[31:0] : s_nxt.num[31:0];
            s_nxt.st     = S_IDLE;
          end else begin
            s_nxt.root = 16'h0;
            s_nxt.rcnt = 4'hF;
            s_nxt.st   = S_ROOT;
          end
        end
      end
      S_ROOT: begin
        if ({16'h0, rt} * {16'h0, rt} <= s_r.num[31:0])
          s_nxt.root = rt;
        s_nxt.rcnt = s_r.rcnt - 4'h1;
        if (s_r.rcnt == 4'h0) begin
          s_nxt.result = {16'h0, s_nxt.root};
          s_nxt.st     = S_IDLE;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r         <= '0;
      s_r.st      <= S_IDLE;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
      s_r.arready <= 1'b1;
      s_r.op      <= OP_HIGH;
      s_r.groups  <= RST_GROUPS;
      s_r.amask   <= RST_ASSIGN;
      s_r.arm     <= RST_ARM;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Sample store; kept apart from the state record because of its size.
  always_ff @(posedge aclk) begin
    if (smp_valid)
      mem[{smp_chan, s_r.wptr[smp_chan]}] <= smp_data;
    rd_q <= mem[{s_r.ch, rd_addr}];
  end

  assign awready   = s_r.awready;
  assign wready    = s_r.wready;
  assign bvalid    = s_r.bvalid;
  assign bresp     = s_r.bresp;
  assign arready   = s_r.arready;
  assign rvalid    = s_r.rvalid;
  assign rdata     = s_r.rdata;
  assign rresp     = s_r.rresp;
  assign out_byte  = s_r.obyte;
  assign out_valid = s_r.ovalid;
  assign err_led   = s_r.led;
endmodule

// [dv/sma_props.sv]
// Port assertions for the sample memory analysis block.
`timescale 1ns/100ps
module sma_props #(
  parameter int BLINK_CYCLES = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [7:0]  out_byte,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        err_led
);
  import sma_pkg::*;
  logic led_q;
  int   run_r;
  // A run counter bounds the high blink phase without a long repetition.
  always_ff @(posedge aclk) begin
    led_q <= err_led;
    run_r <= (!aresetn || err_led != led_q) ? 0 : run_r + 1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_r_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_byte_hold:
    assert property (out_valid && !out_ready |=> $stable(out_byte))
    else $error("stream byte changed while stalled");
  a_byte_valid:
    assert property (out_valid && !out_ready |=> out_valid)
    else $error("stream byte dropped");
  a_b_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");
  a_w_closed:
    assert property (bvalid |-> !awready && !wready)
    else $error("write channel open during response");
  a_led_blink:
    assert property (err_led && led_q |-> run_r < BLINK_CYCLES)
    else $error("indicator high too long");
  a_r_err_zero:
    assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read carries data");
  cover property (bvalid && bready && bresp == RESP_SLVERR);
  cover property ($rose(err_led));
  cover property (out_valid && !out_ready);
endmodule

bind sample_memory_analysis sma_props #(.BLINK_CYCLES(BLINK_CYCLES))
  u_props (.*);

// [dv/host_sink.sv]
// Host side byte sink that collects the block's output stream.
`timescale 1ns/100ps
module host_sink (
  input wire logic       aclk,
  input wire logic [7:0] out_byte,
  input wire logic       out_valid,
  input wire logic       slow,
  output logic           out_ready
);
  logic [1:0] ph_r = 2'h0;
  logic [7:0] got[$];
  initial out_ready = 1'b0;
  // Slow mode takes one byte in four so the stream must stall.
  always @(posedge aclk) begin
    if (out_valid && out_ready) got.push_back(out_byte);
    ph_r <= ph_r + 2'h1;
    out_ready <= slow ? ph_r == 2'h3 : ph_r != 2'h0;
  end
endmodule

// [dv/sample_memory_analysis_tb_top.sv]
// Self-checking bench for the sample memory analysis block.
`timescale 1ns/100ps
module sample_memory_analysis_tb_top;
  import sma_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, out_valid, slow;
  logic        out_ready, err_led, smp_valid, sync_pulse, tick_fast;
  logic        tick_slow, led_seen;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  grp_trig, h;
  logic [7:0]  awaddr, araddr, out_byte;
  logic [15:0] smp_data, s[8];
  logic [31:0] wdata, rdata, rd, st, lfsr;
  int          n_errors, n_tests, e, loc;

  sample_memory_analysis #(.BLINK_CYCLES(4)) dut (.aclk, .aresetn,
    .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .smp_valid,
    .smp_chan(4'h0), .smp_data, .grp_trig, .sync_pulse, .tick_fast,
    .tick_slow, .out_byte, .out_valid, .out_ready, .err_led);
  host_sink u_host (.aclk, .out_byte, .out_valid, .slow, .out_ready);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) if (err_led === 1'b1) led_seen <= 1'b1;

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Odd ops search for a minimum; steps skip the window's first sample.
  function automatic int expv(input int op, lo, n, output int loc);
    int x, d, b, sm;
    longint q;
    b = op % 2 ? 99999 : -99999;
    sm = 0;
    q = 0;
    for (int i = lo; i < lo + n; i++) begin
      x = $signed(s[i]);
      d = op > 3 && i > lo ? x - $signed(s[i - 1]) : x;
      sm += x;
      q += x * x;
      if ((op % 2 ? d < b : d > b) && (op < 4 || i > lo)) begin
        b = d;
        loc = i;
      end
    end
    if (op == 2) return sm / n;
    for (x = 0; (x + 1) * (x + 1) <= q / n; x++);
    return op == 3 ? x : b;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, g, x);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tmo(input bit hit);
    if (hit) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      bready <= bvalid;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(k == 99);
  endtask
  task automatic rg(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      rready <= rvalid;
    end
    rd = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(k == 99);
  endtask
  // Busy falls only once the last byte is taken; the drain is a guard.
  task automatic cmd(input logic [31:0] c);
    int k;
    wr(OFS_CMD, c);
    rd = 32'h1;
    for (k = 0; k < 300 && rd[0] !== 1'b0; k++) rg(OFS_STATUS);
    tmo(k == 300);
    for (k = 0; k < 99 && out_valid !== 1'b0; k++) @(posedge aclk);
    tmo(k == 99);
    repeat (3) @(posedge aclk);
    st = rd;
    $display("command %h finished", c);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, smp_valid, slow} = '0;
    {sync_pulse, tick_fast, tick_slow, led_seen, rd} = '0;
    {awaddr, araddr, wdata, smp_data, grp_trig} = '0;
    lfsr = 32'h63D3;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rg(OFS_GROUPS);
    chk(rd[3:0], RST_GROUPS);
    wr(OFS_ARM, 32'h1);
    sync_pulse <= 1'b1;
    tick_slow <= 1'b1;
    @(posedge aclk);
    sync_pulse <= 1'b0;
    tick_fast <= 1'b1;
    repeat (5) @(posedge aclk);
    tick_fast <= 1'b0;
    grp_trig <= 4'h1;
    @(posedge aclk);
    grp_trig <= 4'h0;
    tick_fast <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      lfsr = nx(lfsr);
      s[i] = i == 1 ? 16'h7FFF : i == 3 ? 16'h8000 : i == 5 ? 16'hFFFF :
             lfsr[15:0];
      smp_valid <= 1'b1;
      smp_data <= s[i];
      @(posedge aclk);
    end
    smp_valid <= 1'b0;
    wr(OFS_ASSIGN, 32'h1);
    for (int p = 0; p < 2; p++) begin
      wr(OFS_COUNT, 8 >> p);
      wr(OFS_OFFSET, 2 * p);
      for (int op = 0; op < 6; op++) begin
        led_seen = 1'b0;
        cmd(op | 16 | 32 * p);
        e = expv(op, 2 * p, 8 >> p, loc);
        rg(OFS_RESULT);
        chk(rd[15:0], e[15:0]);
        rg(OFS_LOC);
        if (op < 2 || op > 3) chk(rd[15:0], loc[15:0]);
        chk({st[4:1], led_seen, err_led}, 6'h02);
      end
    end
    slow <= 1'b1;
    wr(OFS_COUNT, 8);
    cmd(32'h17);
    chk(u_host.got.size(), 16);
    for (int i = 0; i < 8; i++) begin
      chk({u_host.got[2 * i], u_host.got[2 * i + 1]}, s[i]);
    end
    u_host.got.delete();
    slow <= 1'b0;
    wr(OFS_COUNT, 3);
    cmd(32'h16);
    for (int i = 0; i < 15; i++) begin
      h = 4'(s[i / 5] >> (12 - 4 * (i % 5)));
      e = i % 5 < 4 ? (h < 10 ? CH_ZERO : CH_ALPHA) + h : CH_COMMA;
      chk(u_host.got[i], i == 14 ? CH_LF : e);
    end
    cmd(32'h6);
    chk(st[4:1], {ERR_RANGE, 1'b1});
    wr(OFS_COUNT, 1001);
    cmd(32'h16);
    chk(st[4:1], {ERR_RANGE, 1'b1});
    wr(OFS_COUNT, 5001);
    cmd(32'h17);
    chk(st[4:1], {ERR_RANGE, 1'b1});
    u_host.got.delete();
    wr(OFS_CHAN, 2);
    cmd(32'h50);
    chk({st[4:1], 5'(u_host.got.size())}, {ERR_ROUTE, 6'h20});
    cmd(32'h8);
    chk({u_host.got[0], u_host.got[1], u_host.got[2], u_host.got[3]},
        5);
    wr(OFS_ARM, 1);
    wr(OFS_COUNT, 1);
    cmd(32'h10);
    rg(OFS_ARM);
    chk(rd[3:0], 4'h0);
    wr(8'h40, 32'h1);
    chk(r, RESP_SLVERR);
    rg(8'h40);
    chk({r, rd[29:0]}, {RESP_SLVERR, 30'h0});
    report_and_stop();
  end
endmodule
